// file: src/shsf_framer.sv
/*
 * Transmit sync header stream framer for a 64b/66b serial lane: counts blocks into
 * multiblocks and extended multiblocks, prepends sync headers carrying the stream
 * bits, and computes the CRC-12 or FEC parity of each multiblock.
 * Assumes scrambled 64-bit blocks arrive one per clock when valid, SYSREF is
 * synchronous to CORE_CLK, and an APB master reaches the registers.
 * A mode change acts at once, so the multiblock that straddles it carries mixed
 * parity; software should change mode only while blocks are held off.
 * Software picks E so that each extended multiblock holds whole frames; the
 * block does not check frame size.
 */
// Added by the designer: the register offsets and register access over APB.
// Operation
// - A multiblock is exactly 32 consecutive 66-bit blocks.
// - E consecutive multiblocks form one extended multiblock holding whole frames.
// - E is 1 when one multiblock already holds whole frames.
// - SYSREF resets the extended multiblock clock to a fixed phase.
// - Extended multiblock clock has one period per 66*32*E line bits.
// - Every sync header is 01 or 10, its bits always differ.
// - Header 01 sends stream bit 1, header 10 sends bit 0.
// - Stream bits of a multiblock's 32 headers form a 32-bit word in order.
// - Only CRC-12 and FEC stream forms exist; CRC-3 and command channel do not.
// - Every stream ends 00001; in CRC mode nowhere else.
// - Stream bit 22 is 1 only in the last multiblock of an extended one.
// - CRC parity of one multiblock travels in the next multiblock's stream.
// - Earliest CRC detection of a first-bit error is 46 blocks.
// - Mode select value 0 picks CRC-12 mode.
// - CRC bits 0-2,4-6,8-10,12-14 carry parity 11..0; bits 3,7,11,15,19,21,23,31 are 1.
// - CRC command bits are 0, bit 22 is the end flag, bits 27-30 are 0.
// - Parity covers 2048 scrambled payload bits with polynomial 0x987.
// - Parity stages clear before each multiblock; word taken after 2048 bits.
// - Mode select value 2 picks FEC mode.
// - Payload is scrambled before the header is prepended at bits 0 and 1.
`timescale 1ns/1ps

module shsf_framer
	import shsf_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SYSREF,
	input wire logic BLK_VALID,
	input wire logic [63:0] BLK_DATA,
	output logic TX_VALID,
	output logic [65:0] TX_BLOCK,
	output logic TX_EMB_START,
	output logic TX_MB_END
);

	// One parity step over a 64-bit block, first line bit is data bit 63
	function automatic logic [25:0] shsf_par_step(input logic [25:0] st, input logic [63:0] d, input logic fec);
		logic [25:0] s;
		logic fb;
		s = st;
		for (int i = SHSF_BLK_BITS - 1; i >= 0; i--) begin
			fb = d[i] ^ (fec ? s[25] : s[11]);
			s = {s[24:0], 1'b0} ^ (fb ? (fec ? SHSF_FEC_POLY : SHSF_CRC_POLY) : SHSF_PAR_ZERO);
			if (!fec) begin
				s[25:12] = 14'h0000;
			end
		end
		return s;
	endfunction : shsf_par_step

	// Build the 32-bit sync header stream for one multiblock
	function automatic logic [31:0] shsf_stream_word(input logic fec, input logic [25:0] p, input logic emb_end);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (fec) begin
			for (int i = 0; i < 22; i++) begin
				w[i] = p[25 - i];
			end
			w[23] = p[3];
			w[24] = p[2];
			w[25] = p[1];
			w[26] = p[0];
		end else begin
			for (int g = 0; g < 4; g++) begin
				w[4 * g] = p[11 - 3 * g];
				w[4 * g + 1] = p[10 - 3 * g];
				w[4 * g + 2] = p[9 - 3 * g];
				w[4 * g + 3] = 1'b1;
			end
			w[19] = 1'b1;
			w[21] = 1'b1;
			w[23] = 1'b1; // Command bits 16-18, 20, 24-26 stay 0
		end
		w[SHSF_EMB_END_BIT] = emb_end;
		w[31] = 1'b1; // Bits 27-30 stay 0 ahead of the final 1
		return w;
	endfunction : shsf_stream_word

	shsf_ctrl_s ctrl_r;
	logic [31:0] prdata_r;
	logic sysref_d_r;
	logic seen_r;
	logic [4:0] blk_r;
	logic [7:0] mb_r;
	logic [25:0] par_r;
	logic [25:0] hold_r;
	logic tx_valid_r;
	logic [65:0] tx_block_r;
	logic emb_start_r;
	logic mb_end_r;

	// APB decode
	wire logic setup_phase = PSEL && !PENABLE;
	wire logic access_phase = PSEL && PENABLE;
	wire logic hit_ctrl = (PADDR == SHSF_ADDR_CTRL);
	wire logic hit_status = (PADDR == SHSF_ADDR_STATUS);
	wire logic hit_parity = (PADDR == SHSF_ADDR_PARITY);
	wire logic addr_ok = hit_ctrl || hit_status || hit_parity;
	wire logic wr_ctrl = access_phase && PWRITE && hit_ctrl;
	wire logic [1:0] wr_mode = PWDATA[SHSF_CTRL_MODE_LSB +: 2];
	wire logic mode_ok = (wr_mode == SHSF_MODE_CRC) || (wr_mode == SHSF_MODE_FEC);
	wire logic [31:0] ctrl_word = {16'h0000, ctrl_r.emb_len_m1, 3'h0, ctrl_r.enable, 2'h0, ctrl_r.mode};
	wire logic [31:0] stat_word = {15'h0000, seen_r, mb_r, 3'h0, blk_r};
	wire logic [31:0] rd_mux = hit_ctrl ? ctrl_word : hit_status ? stat_word :
		hit_parity ? {6'h00, hold_r} : 32'h0000_0000;

	// Next control value; unsupported mode codes leave the mode unchanged
	wire logic [1:0] mode_nxt = mode_ok ? wr_mode : ctrl_r.mode;
	wire shsf_ctrl_s ctrl_nxt = '{emb_len_m1: PWDATA[SHSF_CTRL_EMB_LSB +: 8],
		enable: PWDATA[SHSF_CTRL_EN_BIT], mode: mode_nxt};

	// Block position, restarted by a SYSREF rising edge
	wire logic sys_edge = SYSREF && !sysref_d_r;
	wire logic fec_mode = (ctrl_r.mode == SHSF_MODE_FEC);
	wire logic take = BLK_VALID && ctrl_r.enable;
	wire logic [4:0] cur_blk = sys_edge ? 5'h00 : blk_r;
	wire logic [7:0] cur_mb = sys_edge ? 8'h00 : mb_r;
	wire logic last_blk = (cur_blk == SHSF_LAST_BLK);
	wire logic last_mb = (cur_mb == ctrl_r.emb_len_m1);
	wire logic [4:0] blk_nxt = last_blk ? 5'h00 : 5'(cur_blk + 5'h01);
	wire logic [7:0] mb_nxt = !last_blk ? cur_mb : last_mb ? 8'h00 : 8'(cur_mb + 8'h01);

	// Parity accumulator restarts from zero on each multiblock
	wire logic [25:0] par_base = sys_edge ? SHSF_PAR_ZERO : par_r;
	wire logic [25:0] par_step = shsf_par_step(par_base, BLK_DATA, fec_mode);

	// Stream bit of the current block and its sync header
	wire logic [31:0] stream_word = shsf_stream_word(fec_mode, hold_r, last_mb);
	wire logic stream_bit = stream_word[cur_blk];
	wire logic [1:0] sync_hdr = {~stream_bit, stream_bit};

	// APB handshake: zero wait states, error on unmapped addresses
	assign PREADY = 1'b1;
	assign PSLVERR = access_phase && !addr_ok;
	assign PRDATA = prdata_r;
	assign TX_VALID = tx_valid_r;
	assign TX_BLOCK = tx_block_r;
	assign TX_EMB_START = emb_start_r;
	assign TX_MB_END = mb_end_r;

	// Control register, E resets to one multiblock
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_r <= SHSF_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_r <= rd_mux;
		end
	end

	// SYSREF edge detector and seen flag
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sysref_d_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			sysref_d_r <= SYSREF;
			seen_r <= seen_r || sys_edge;
		end
	end

	// Block and multiblock counters
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			blk_r <= 5'h00;
			mb_r <= 8'h00;
		end else if (take) begin
			blk_r <= blk_nxt;
			mb_r <= mb_nxt;
		end else begin
			blk_r <= cur_blk;
			mb_r <= cur_mb;
		end
	end

	// Parity accumulation and hand-off to the holding register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			par_r <= SHSF_PAR_ZERO;
			hold_r <= SHSF_PAR_ZERO;
		end else if (take && last_blk) begin
			par_r <= SHSF_PAR_ZERO;
			hold_r <= par_step;
		end else if (take) begin
			par_r <= par_step;
		end else begin
			par_r <= par_base;
		end
	end

	// Output block: header prepended to the already scrambled payload
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tx_valid_r <= 1'b0;
			tx_block_r <= 66'h0_0000_0000_0000_0000;
			emb_start_r <= 1'b0;
			mb_end_r <= 1'b0;
		end else begin
			tx_valid_r <= take;
			if (take) begin
				tx_block_r <= {sync_hdr, BLK_DATA};
			end
			emb_start_r <= take && (cur_blk == 5'h00) && (cur_mb == 8'h00);
			mb_end_r <= take && last_blk;
		end
	end

	// Sync header bits always differ
	AST_HDR_DIFFERS: assert property (@(posedge CORE_CLK) disable iff (RST)
		TX_VALID |-> (TX_BLOCK[65] != TX_BLOCK[64]))
		else $error("sync header bits equal");

	// Block counter steps by one per accepted block and wraps at 31
	AST_BLK_STEP: assert property (@(posedge CORE_CLK) disable iff (RST)
		(take && !sys_edge) |=> (blk_r == (($past(blk_r) == SHSF_LAST_BLK) ? 5'h00 : 5'($past(blk_r) + 5'h01))))
		else $error("block counter did not advance correctly");

	// Blocks 27 to 30 send stream bit 0, block 31 sends 1
	AST_PILOT: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && (cur_blk >= 5'd27) |=> (TX_BLOCK[64] == ($past(cur_blk) == SHSF_LAST_BLK)))
		else $error("end of multiblock pilot wrong");

	// End flag at bit 22 tracks the last multiblock of the extended multiblock
	AST_EXTENDED_MULTIBLOCK_END_FLAG: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && (cur_blk == 5'd22) |=> (TX_BLOCK[64] == $past(last_mb)))
		else $error("extended multiblock end flag wrong");

	// A SYSREF edge makes the block in that cycle the first of an extended multiblock
	AST_SYSREF_PHASE: assert property (@(posedge CORE_CLK) disable iff (RST)
		(sys_edge && take) |=> TX_EMB_START)
		else $error("SYSREF did not realign the extended multiblock clock");

	// In CRC mode the fixed-one positions below 31 send 1
	AST_CRC_ONES: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && !fec_mode && (((cur_blk[1:0] == 2'b11) && (cur_blk < 5'd24)) || (cur_blk == 5'd21))
		|=> TX_BLOCK[64])
		else $error("fixed one missing in CRC stream");

	// In CRC mode command bits and bits 27-30 send 0
	AST_CRC_ZEROS: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && !fec_mode && ((cur_blk >= 5'd16 && cur_blk <= 5'd18) || cur_blk == 5'd20 ||
		(cur_blk >= 5'd24 && cur_blk <= 5'd30)) |=> !TX_BLOCK[64])
		else $error("command or reserved bit not zero");

	// Holding register changes only at a multiblock end
	AST_HOLD_STABLE: assert property (@(posedge CORE_CLK) disable iff (RST)
		!(take && last_blk) |=> $stable(hold_r))
		else $error("parity hold changed inside a multiblock");

	// Accumulator is zero at the start of each multiblock
	AST_PAR_CLEAR: assert property (@(posedge CORE_CLK) disable iff (RST)
		(take && last_blk) |=> (par_r == SHSF_PAR_ZERO))
		else $error("parity stages not cleared");

	// Unsupported mode codes are not stored
	AST_MODE_ONLY: assert property (@(posedge CORE_CLK) disable iff (RST)
		wr_ctrl && !mode_ok |=> (ctrl_r.mode == $past(ctrl_r.mode)))
		else $error("unsupported sync header mode accepted");

	// Parity bit 11 appears on the header of block 0 in CRC mode
	AST_CRC_MAP: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && !fec_mode && (cur_blk == 5'd0) |=> (TX_BLOCK[64] == $past(hold_r[11])))
		else $error("parity bit 11 not at stream bit 0");

	// Unmapped addresses answer with an error and read back zero
	AST_UNMAPPED: assert property (@(posedge CORE_CLK) disable iff (RST)
		access_phase && !addr_ok |-> PSLVERR && (PRDATA == 32'h0000_0000))
		else $error("unmapped address without error or with data");

	// FEC stream opens with the top parity bit
	AST_FEC_MAP: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && fec_mode && (cur_blk == 5'h00) |=> (TX_BLOCK[64] == $past(hold_r[25])))
		else $error("FEC parity bit 25 not at stream bit 0");

	// FEC parity bit 0 rides on block 26
	AST_FEC_LOW: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && fec_mode && (cur_blk == 5'd26) |=> (TX_BLOCK[64] == $past(hold_r[0])))
		else $error("FEC parity bit 0 not at stream bit 26");

	// CRC parity bit 0 rides on block 14
	AST_CRC_LOW: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && !fec_mode && (cur_blk == 5'd14) |=> (TX_BLOCK[64] == $past(hold_r[0])))
		else $error("CRC parity bit 0 not at stream bit 14");

	// Multiblock end marker goes with block 31 only
	AST_MB_END: assert property (@(posedge CORE_CLK) disable iff (RST)
		take |=> (TX_MB_END == ($past(cur_blk) == SHSF_LAST_BLK)))
		else $error("multiblock end marker misplaced");

	// An output block follows each accepted block, and only then
	AST_TX_VALID: assert property (@(posedge CORE_CLK) disable iff (RST)
		1'b1 |=> (TX_VALID == $past(take)))
		else $error("output valid does not follow accepted block");

	// Payload passes unchanged behind the header
	AST_PAYLOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
		take |=> (TX_BLOCK[63:0] == $past(BLK_DATA)))
		else $error("payload altered");

	// Output block holds between accepted blocks
	AST_BLOCK_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
		!take |=> $stable(TX_BLOCK))
		else $error("output block changed without a new block");

	// Last block of the last multiblock wraps both counters
	AST_EMB_WRAP: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && last_blk && last_mb |=> (blk_r == 5'h00) && (mb_r == 8'h00))
		else $error("extended multiblock did not wrap");

	// Other multiblock ends advance the multiblock counter
	AST_MB_ADVANCE: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && last_blk && !last_mb |=> (mb_r == 8'($past(cur_mb) + 8'h01)))
		else $error("multiblock counter did not advance");

	// Counters wait while no block is accepted and no SYSREF edge arrives
	AST_COUNT_IDLE: assert property (@(posedge CORE_CLK) disable iff (RST)
		!take && !sys_edge |=> ($stable(blk_r) && $stable(mb_r)))
		else $error("counters moved without a block");

	// A SYSREF edge without a block still restarts position and parity
	AST_SYSREF_CLEAR: assert property (@(posedge CORE_CLK) disable iff (RST)
		sys_edge && !take |=> (blk_r == 5'h00) && (mb_r == 8'h00) && (par_r == SHSF_PAR_ZERO))
		else $error("idle SYSREF did not restart the counters");

	// CRC mode keeps the upper parity stages empty
	AST_CRC_NARROW: assert property (@(posedge CORE_CLK) disable iff (RST)
		take && !fec_mode |=> (par_r[25:12] == 14'h0000))
		else $error("CRC parity wider than 12 bits");

	// SYSREF seen flag sets on the edge
	AST_SEEN_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
		sys_edge |=> seen_r)
		else $error("SYSREF seen flag not set");

	// Supported mode codes are stored as written
	AST_MODE_STORE: assert property (@(posedge CORE_CLK) disable iff (RST)
		wr_ctrl && mode_ok |=> (ctrl_r.mode == $past(wr_mode)))
		else $error("supported mode not stored");

endmodule : shsf_framer

// file: src/shsf_pkg.sv
/*
 * Shared constants and types for the sync header stream framer: register map,
 * field positions, reset values, sync header modes and parity polynomials.
 * Assumes a 32-bit APB register bus with byte addresses and one word per register.
 */
package shsf_pkg;

	// Block and multiblock geometry
	localparam int SHSF_BLK_PER_MB = 32;
	localparam int SHSF_BLK_BITS = 64;
	localparam int SHSF_BLK_IDX_W = 5;
	localparam logic [4:0] SHSF_LAST_BLK = 5'h1f;

	// Register byte offsets
	localparam logic [7:0] SHSF_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SHSF_ADDR_STATUS = 8'h04;
	localparam logic [7:0] SHSF_ADDR_PARITY = 8'h08;

	// Control field positions
	localparam int SHSF_CTRL_MODE_LSB = 0;
	localparam int SHSF_CTRL_EN_BIT = 4;
	localparam int SHSF_CTRL_EMB_LSB = 8;

	// Status field positions
	localparam int SHSF_STAT_BLK_LSB = 0;
	localparam int SHSF_STAT_MB_LSB = 8;
	localparam int SHSF_STAT_SEEN_BIT = 16;

	// Sync header mode select codes
	localparam logic [1:0] SHSF_MODE_CRC = 2'h0;
	localparam logic [1:0] SHSF_MODE_FEC = 2'h2;

	// Parity polynomials without the leading term; the CRC-12 code 0x987 keeps the
	// x^12 term as its top bit and leaves the +1 implied, so its taps are 0x30F
	localparam logic [25:0] SHSF_CRC_POLY = 26'h000_030F;
	localparam logic [25:0] SHSF_FEC_POLY = 26'h022_0211;
	localparam logic [25:0] SHSF_PAR_ZERO = 26'h000_0000;

	// Sync header stream positions
	localparam int SHSF_EMB_END_BIT = 22;

	// Control register contents
	typedef struct packed {
		logic [7:0] emb_len_m1;
		logic enable;
		logic [1:0] mode;
	} shsf_ctrl_s;

	// After reset: CRC-12 mode, disabled, one multiblock per extended multiblock
	localparam shsf_ctrl_s SHSF_CTRL_RST = '{emb_len_m1: 8'h00, enable: 1'b0, mode: 2'h0};

endpackage : shsf_pkg

// file: verification/shsf_framer_tb.sv
/*
 * Self-checking bench for the sync header stream framer: APB setup, CRC and FEC runs.
 * Assumes zero-wait APB and one block per cycle while BLK_VALID is high.
 */
`timescale 1ns/1ps

module shsf_framer_tb
	import shsf_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sysref = 1'b0;
	logic bvalid = 1'b0;
	logic [63:0] bdata = 64'h0000_0000_0000_0000;
	logic txv;
	logic [65:0] txb;
	logic embs;
	logic mbe;
	logic [31:0] word;
	int hdr_err;
	int embc;
	int pilot_err;
	int error_cnt = 0;
	int checked = 0;
	logic [31:0] r;
	logic e;

	// Clock
	always #5 clk = ~clk;

	shsf_framer dut_u (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SYSREF(sysref),
		.BLK_VALID(bvalid), .BLK_DATA(bdata), .TX_VALID(txv), .TX_BLOCK(txb), .TX_EMB_START(embs),
		.TX_MB_END(mbe));

	shsf_rx_model rx_u (.clk(clk), .rst(rst), .tx_valid(txv), .tx_block(txb), .tx_emb_start(embs),
		.tx_mb_end(mbe), .mb_word(word), .hdr_err_cnt(hdr_err), .emb_cnt(embc), .pilot_err_cnt(pilot_err));

	// Payload of block b in multiblock m
	function automatic logic [63:0] dat(input int m, input int b);
		return {16'(m * 32 + b), 16'hC3A5, ~16'(m * 32 + b), 16'(b * 7)};
	endfunction : dat

	// Reference parity: bit 63 first, stages cleared per multiblock
	function automatic logic [25:0] par(input int n, input logic [25:0] poly, input int m);
		logic [25:0] s;
		logic [25:0] top;
		logic [25:0] mask;
		logic [63:0] d;
		logic fb;
		s = '0;
		top = 26'h000_0001 << (n - 1);
		mask = (top << 1) - 26'h000_0001;
		for (int b = 0; b < 32; b++) begin
			d = dat(m, b);
			for (int i = 63; i >= 0; i--) begin
				fb = d[i] ^ (|(s & top));
				s = ((s << 1) & mask) ^ (fb ? poly : 26'h000_0000);
			end
		end
		return s;
	endfunction : par

	// Expected sync header stream word
	function automatic logic [31:0] exp_word(input logic fec, input logic [25:0] p, input logic eo);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (fec) begin
			for (int k = 0; k < 22; k++) w[k] = p[25 - k];
			for (int k = 0; k < 4; k++) w[23 + k] = p[3 - k];
		end else begin
			w = 32'h80A8_8888;
			for (int g = 0; g < 4; g++) begin
				for (int j = 0; j < 3; j++) w[4 * g + j] = p[11 - 3 * g - j];
			end
		end
		w[22] = eo;
		w[31] = 1'b1;
		return w;
	endfunction : exp_word

	// One APB transfer
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Send one multiblock, SYSREF with its first block if asked
	task automatic send_mb(input int m, input logic sr);
		for (int b = 0; b < 32; b++) begin
			@(posedge clk);
			bvalid <= 1'b1;
			bdata <= dat(m, b);
			sysref <= sr && (b == 0);
		end
		@(posedge clk);
		bvalid <= 1'b0;
		sysref <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : send_mb

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	// Watchdog
	initial begin
		#100us;
		error_cnt++;
		stop_test();
	end

	// Test sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, SHSF_ADDR_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		chk(r, 32'h0000_0000);
		$display("test registers done");
		apb(1'b1, SHSF_ADDR_CTRL, 32'h0000_0110);
		for (int m = 0; m < 3; m++) begin
			send_mb(m, m == 0);
			chk(word, exp_word(1'b0, (m == 0) ? 26'h0 : par(12, SHSF_CRC_POLY, m - 1), m == 1));
		end
		apb(1'b0, SHSF_ADDR_PARITY, 32'h0000_0000);
		chk(r, {6'h00, par(12, SHSF_CRC_POLY, 2)});
		chk(32'(embc), 32'h0000_0002);
		apb(1'b0, SHSF_ADDR_STATUS, 32'h0000_0000);
		chk(r, 32'h0001_0100);
		$display("test crc done");
		apb(1'b1, SHSF_ADDR_CTRL, 32'h0000_0012);
		apb(1'b1, SHSF_ADDR_CTRL, 32'h0000_0011);
		apb(1'b0, SHSF_ADDR_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_0012);
		@(posedge clk);
		sysref <= 1'b1;
		@(posedge clk);
		sysref <= 1'b0;
		send_mb(10, 1'b1);
		send_mb(11, 1'b0);
		chk(word, exp_word(1'b1, par(26, SHSF_FEC_POLY, 10), 1'b1));
		chk(32'(embc), 32'h0000_0004);
		chk(32'(hdr_err), 32'h0000_0000);
		chk(32'(pilot_err), 32'h0000_0000);
		chk({30'h0000_0000, txb[65:64]}, 32'h0000_0001);
		chk(txb[63:32], 32'(dat(11, 31) >> 32));
		chk(txb[31:0], 32'(dat(11, 31)));
		$display("test fec done");
		stop_test();
	end

endmodule : shsf_framer_tb

// file: verification/shsf_rx_model.sv
/*
 * Far-side receiver model: gathers the sync header stream of each multiblock.
 * Assumes it watches the framer's registered transmit outputs on CORE_CLK.
 */
`timescale 1ns/1ps

module shsf_rx_model
	import shsf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_valid,
	input wire logic [65:0] tx_block,
	input wire logic tx_emb_start,
	input wire logic tx_mb_end,
	output logic [31:0] mb_word,
	output int hdr_err_cnt,
	output int emb_cnt,
	output int pilot_err_cnt
);
	logic [31:0] sh_r;
	logic [31:0] sh_nxt;

	// Stream bit of block k ends up in bit k after 32 blocks
	assign sh_nxt = {tx_block[64], sh_r[31:1]};

	// Collect stream bits, count bad headers and extended multiblock starts
	always_ff @(posedge clk) begin
		if (rst) begin
			sh_r <= '0;
			mb_word <= '0;
			hdr_err_cnt <= 0;
			emb_cnt <= 0;
			pilot_err_cnt <= 0;
		end else if (tx_valid) begin
			sh_r <= sh_nxt;
			if (tx_block[65] == tx_block[64]) begin
				hdr_err_cnt <= hdr_err_cnt + 1;
			end
			if (tx_emb_start) begin
				emb_cnt <= emb_cnt + 1;
			end
			if (tx_mb_end) begin
				mb_word <= sh_nxt;
				// Pilot must close every multiblock at the same place
				if (sh_nxt[31:27] != 5'h10) begin
					pilot_err_cnt <= pilot_err_cnt + 1;
				end
			end
		end
	end

endmodule : shsf_rx_model
